/* include/rscc_pkg.sv */
// Purpose: Constants for the serial port configuration block
// Assumes: 100 MHz clock
// Notes:   Times are in their printed unit, cycles derived
package rscc_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_US_X10 = 1000;  // 0.1 ms in 0.1 us units
  localparam int TICK_CYCLES = CLK_HZ / 10_000;
  // Bit rate codes
  localparam logic [2:0] BAUD_9600 = 3'h0;
  localparam logic [2:0] BAUD_19200 = 3'h1;
  localparam logic [2:0] BAUD_38400 = 3'h2;
  localparam logic [2:0] BAUD_57600 = 3'h3;
  localparam logic [2:0] BAUD_115200 = 3'h4;
  localparam logic [2:0] BAUD_230400 = 3'h5;
  localparam logic [2:0] BAUD_RST = BAUD_115200;
  // Parity and stop codes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic STOP_ONE = 1'h0;
  localparam logic STOP_TWO = 1'h1;
  // Word order bits
  localparam int ORD_LOW_FIRST = 0;
  localparam int ORD_LITTLE = 1;
  localparam logic [1:0] ORD_RST = 2'h0;
  // Address settings, signed 5 bits
  localparam logic [4:0] ADDR_FROM_SW = 5'h1F;
  localparam logic [4:0] GRP_OFF = 5'h1F;
  localparam logic [3:0] ADDR_ZERO = 4'h0;
  // Limits and reset values
  localparam logic [13:0] TMO_MS_MAX = 14'h2710;
  localparam logic [3:0] ERR_LIM_MAX = 4'hA;
  localparam logic [13:0] WAIT_RST = 14'h001E;  // 3.0 ms
  localparam logic [6:0] SILENT_AUTO = 7'h00;
  localparam logic ERRRESP_RST = 1'h1;
  localparam logic MON_ALL = 1'h0;
  localparam logic SERIAL_EN_RST = 1'h1;
  localparam logic [29:0] SERIAL_MAX = 30'h3B9AC9FF;
  localparam logic [29:0] SERIAL_RST = 30'h00000000;
  localparam logic [4:0] PRODUCT_RST = 5'h00;
  localparam logic [29:0] LFSR_SEED = 30'h2AC3_5A17;
  localparam int MS_TICKS = 10;
  // Frame gap of 3.5 chars of 11 bits, in half bit times
  localparam int GAP_HALF_BITS = 77;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 8;
endpackage

/* verilog/rscc_comm_config.sv */
// Purpose: Setting, update and supervision logic of a slave serial port
// Assumes: Frame engine on the same clock; switch pins are asynchronous
// Notes:   Captured bytes pass a FIFO whose reader may stall
`timescale 1ns/1ps
// What this block does
// - Code selects bit rate, 115200 at reset
// - Code selects none, even or odd parity
// - Code selects one or two stop bits
// - Address 1..15, or switch when minus one
// - Code selects word and byte order
// - Timeout alarm when no valid own or group frame arrives
// - Error alarm when error count reaches limit
// - Wait configured time before starting reply
// - Gap set, or derived from bit rate
// - Slave error gives normal or exception reply
// - Group address accepted, minus one disables
// - Monitor captures all or own packets
// - Serial enable off substitutes random serial
// - Serial number presented from power-on
// - Product code presented on service port
// - Settings apply immediately, on command, or power-up

// ==========================================
// Capture FIFO
module rscc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic [AW:0]      count_d;
  wire              push = inValid & inReady;
  wire              pop = outValid & outReady;

  assign count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign outData = mem[rdPtr_q];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  // Flags registered from the next count, so both stay honest
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      inReady <= 1'b1;
      outValid <= 1'b0;
    end else begin
      wrPtr_q <= wrPtr_q + AW'(push);
      rdPtr_q <= rdPtr_q + AW'(pop);
      count_q <= count_d;
      inReady <= count_d != (AW+1)'(DEPTH);
      outValid <= count_d != '0;
    end
  end
endmodule

// ==========================================
// Top
module rscc_comm_config #(
  parameter int TICK_CYCLES = rscc_pkg::TICK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [2:0]  baudCode,
  input  wire logic [1:0]  parityCode,
  input  wire logic        stopCode,
  input  wire logic [4:0]  slaveIdCfg,
  input  wire logic [3:0]  addrSwitch,
  input  wire logic [1:0]  orderCode,
  input  wire logic [13:0] timeoutMs,
  input  wire logic [3:0]  errLimit,
  input  wire logic [13:0] waitTenthMs,
  input  wire logic [6:0]  silentTenthMs,
  input  wire logic        errRespMode,
  input  wire logic [4:0]  groupIdCfg,
  input  wire logic        monitorMode,
  input  wire logic        serialEnable,
  input  wire logic [29:0] serialCfg,
  input  wire logic [4:0]  productCfg,
  input  wire logic        configCmd,
  input  wire logic        frameValid,
  input  wire logic [3:0]  frameAddr,
  input  wire logic        frameError,
  input  wire logic        errClear,
  input  wire logic        requestDone,
  input  wire logic        slaveError,
  input  wire logic        rxByteValid,
  input  wire logic        rxByteOwn,
  input  wire logic [7:0]  rxByte,
  output logic             rxReady,
  output logic             monValid,
  input  wire logic        monReady,
  output logic [7:0]       monData,
  output logic [15:0]      bitDivisor,
  output logic             parityEnable,
  output logic             parityOdd,
  output logic             stopTwo,
  output logic [3:0]       ownAddr,
  output logic [3:0]       groupAddr,
  output logic             groupEnable,
  output logic             wordLowFirst,
  output logic             byteLittle,
  output logic [23:0]      silentCycles,
  output logic             timeoutAlarm,
  output logic             errorAlarm,
  output logic             replyStart,
  output logic             replyException,
  output logic [29:0]      serialNumber,
  output logic [4:0]       productCode
);
  typedef enum logic [1:0] {
    RP_IDLE = 2'b00,
    RP_WAIT = 2'b01,
    RP_FIRE = 2'b10
  } rscc_reply_t;

  // Clock cycles per bit for a rate code
  function automatic logic [15:0] bitCycles(input logic [2:0] code);
    case (code)
      rscc_pkg::BAUD_9600:   bitCycles = 16'(rscc_pkg::CLK_HZ / 9600);
      rscc_pkg::BAUD_19200:  bitCycles = 16'(rscc_pkg::CLK_HZ / 19200);
      rscc_pkg::BAUD_38400:  bitCycles = 16'(rscc_pkg::CLK_HZ / 38400);
      rscc_pkg::BAUD_57600:  bitCycles = 16'(rscc_pkg::CLK_HZ / 57600);
      rscc_pkg::BAUD_230400: bitCycles = 16'(rscc_pkg::CLK_HZ / 230400);
      default:               bitCycles = 16'(rscc_pkg::CLK_HZ / 115200);
    endcase
  endfunction

  // ==========================================
  // Switch synchroniser and address choice
  logic [3:0]  swMeta_q;
  logic [3:0]  swSync_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      swMeta_q <= 4'h0;
      swSync_q <= 4'h0;
    end else begin
      swMeta_q <= addrSwitch;
      swSync_q <= swMeta_q;
    end
  end

  // Zero is illegal; it falls back to the switch rather than answer nobody
  wire useSwitch = slaveIdCfg[4] | (slaveIdCfg[3:0] == rscc_pkg::ADDR_ZERO);
  wire [3:0] addrNext = useSwitch ? swSync_q : slaveIdCfg[3:0];
  wire grpOn = !groupIdCfg[4] && groupIdCfg[3:0] != rscc_pkg::ADDR_ZERO;

  // ==========================================
  // Update classes
  logic        powerUp_q;
  logic        cfgDone_q;
  logic [29:0] lfsr_q;
  logic [6:0]  silentTenth_q;
  wire         applyCfg = configCmd | ~cfgDone_q;
  wire [29:0]  randSerial = {1'b0, lfsr_q[28:0]};

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lfsr_q <= rscc_pkg::LFSR_SEED;
    end else begin
      lfsr_q <= {lfsr_q[28:0], lfsr_q[29] ^ lfsr_q[5] ^ lfsr_q[3] ^ lfsr_q[0]};
    end
  end

  // Power-up class settings are caught once, one edge after release
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      powerUp_q <= 1'b0;
      serialNumber <= rscc_pkg::SERIAL_RST;
      productCode <= rscc_pkg::PRODUCT_RST;
      silentTenth_q <= rscc_pkg::SILENT_AUTO;
      wordLowFirst <= rscc_pkg::ORD_RST[rscc_pkg::ORD_LOW_FIRST];
      byteLittle <= rscc_pkg::ORD_RST[rscc_pkg::ORD_LITTLE];
    end else if (!powerUp_q) begin
      powerUp_q <= 1'b1;
      serialNumber <= serialEnable ? serialCfg : randSerial;
      productCode <= productCfg;
      silentTenth_q <= silentTenthMs;
      wordLowFirst <= orderCode[rscc_pkg::ORD_LOW_FIRST];
      byteLittle <= orderCode[rscc_pkg::ORD_LITTLE];
    end
  end

  // Configuration class: taken at the first edge and on each command
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfgDone_q <= 1'b0;
      bitDivisor <= bitCycles(rscc_pkg::BAUD_RST);
      parityEnable <= 1'b0;
      parityOdd <= 1'b0;
      stopTwo <= rscc_pkg::STOP_ONE;
      ownAddr <= 4'h0;
      groupAddr <= 4'h0;
      groupEnable <= 1'b0;
    end else if (applyCfg) begin
      cfgDone_q <= 1'b1;
      bitDivisor <= bitCycles(baudCode);
      parityEnable <= parityCode != rscc_pkg::PAR_NONE;
      parityOdd <= parityCode == rscc_pkg::PAR_ODD;
      stopTwo <= stopCode == rscc_pkg::STOP_TWO;
      ownAddr <= addrNext;
      groupAddr <= groupIdCfg[3:0];
      groupEnable <= grpOn;
    end
  end

  // Auto gap: 3.5 characters of 11 bits at the live rate
  wire [23:0] autoGap = 24'((32'(bitDivisor) * rscc_pkg::GAP_HALF_BITS) >> 1);
  wire [23:0] setGap = 24'(32'(silentTenth_q) * TICK_CYCLES);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      silentCycles <= 24'h000000;
    end else begin
      silentCycles <= (silentTenth_q == rscc_pkg::SILENT_AUTO) ? autoGap : setGap;
    end
  end

  // ==========================================
  // Timeout monitor on a 0.1 ms tick
  logic [13:0] pre_q;
  logic [17:0] tmoCnt_q;
  wire         tick = pre_q == 14'(TICK_CYCLES - 1);
  wire         ownFrame = frameValid & (frameAddr == ownAddr | (groupEnable & frameAddr == groupAddr));
  wire         tmoOff = timeoutMs == 14'h0000;
  wire [17:0]  tmoLimit = 18'(32'(timeoutMs) * rscc_pkg::MS_TICKS);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pre_q <= 14'h0000;
      tmoCnt_q <= 18'h00000;
      timeoutAlarm <= 1'b0;
    end else begin
      // Prescaler restarts with the count, else the alarm could come up to a tick early
      pre_q <= (tick || tmoOff || ownFrame) ? 14'h0000 : pre_q + 14'h0001;
      if (tmoOff || ownFrame) begin
        tmoCnt_q <= 18'h00000;
        timeoutAlarm <= 1'b0;
      end else if (tick && tmoCnt_q < tmoLimit) begin
        tmoCnt_q <= tmoCnt_q + 18'h00001;
      end else if (tmoCnt_q >= tmoLimit) begin
        timeoutAlarm <= 1'b1;
      end
    end
  end

  // ==========================================
  // Error counter, limit is immediate
  logic [3:0] errCnt_q;
  wire  [3:0] errBase = errClear ? 4'h0 : errCnt_q;
  // Saturates so a long error burst cannot wrap the alarm off
  wire  [3:0] errNext = (frameError && errBase != 4'hF) ? errBase + 4'h1 : errBase;
  wire        errOff = errLimit == 4'h0;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      errCnt_q <= 4'h0;
      errorAlarm <= 1'b0;
    end else begin
      // A new error in the clearing cycle still counts
      if (errOff) begin
        errCnt_q <= 4'h0;
      end else begin
        errCnt_q <= errNext;
      end
      errorAlarm <= !errOff && (errNext >= errLimit);
    end
  end

  // ==========================================
  // Reply wait timer
  rscc_reply_t rpState_q;
  logic [13:0] rpTenth_q;
  logic [13:0] rpPre_q;
  logic        rpErr_q;
  wire         rpTick = rpPre_q == 14'(TICK_CYCLES - 1);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rpState_q <= RP_IDLE;
      rpTenth_q <= 14'h0000;
      rpPre_q <= 14'h0000;
      rpErr_q <= 1'b0;
      replyStart <= 1'b0;
      replyException <= 1'b0;
    end else begin
      replyStart <= 1'b0;
      case (rpState_q)
        RP_IDLE: begin
          if (requestDone) begin
            rpTenth_q <= waitTenthMs;
            rpPre_q <= 14'h0000;
            rpErr_q <= slaveError;
            rpState_q <= RP_WAIT;
          end
        end
        RP_WAIT: begin
          if (rpTenth_q == 14'h0000) begin
            rpState_q <= RP_FIRE;
          end else begin
            rpPre_q <= rpTick ? 14'h0000 : rpPre_q + 14'h0001;
            rpTenth_q <= rpTick ? rpTenth_q - 14'h0001 : rpTenth_q;
          end
        end
        RP_FIRE: begin
          replyStart <= 1'b1;
          replyException <= rpErr_q & errRespMode;
          rpState_q <= RP_IDLE;
        end
        default: rpState_q <= RP_IDLE;
      endcase
    end
  end

  // ==========================================
  // Packet monitor capture
  logic fifoInReady;
  wire  capture = rxByteValid & (monitorMode == rscc_pkg::MON_ALL | rxByteOwn);

  rscc_fifo #(
    .WIDTH (rscc_pkg::FIFO_WIDTH),
    .DEPTH (rscc_pkg::FIFO_DEPTH)
  ) uFifo (
    .clock    (clock),
    .nrst     (nrst),
    .inValid  (capture),
    .inReady  (fifoInReady),
    .inData   (rxByte),
    .outValid (monValid),
    .outReady (monReady),
    .outData  (monData)
  );
  assign rxReady = fifoInReady;

  // ==========================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_baud_reset_rate: assert property ($rose(cfgDone_q) |-> bitDivisor == bitCycles($past(baudCode)))
    else $error("bit rate not taken from code");
  a_parity_odd_map: assert property (configCmd |=> parityOdd == ($past(parityCode) == rscc_pkg::PAR_ODD))
    else $error("parity odd flag wrong");
  a_stop_two_map: assert property (configCmd |=> stopTwo == $past(stopCode))
    else $error("stop length wrong");
  a_addr_switch_use: assert property (configCmd && slaveIdCfg == rscc_pkg::ADDR_FROM_SW |=> ownAddr == $past(swSync_q))
    else $error("switch address not used");
  a_order_frozen: assert property (powerUp_q |=> $stable(wordLowFirst) && $stable(byteLittle))
    else $error("word order changed after power-up");
  a_timeout_off_clear: assert property (tmoOff |=> !timeoutAlarm)
    else $error("timeout alarm while disabled");
  a_timeout_restart: assert property (ownFrame |=> tmoCnt_q == 18'h00000 && !timeoutAlarm)
    else $error("own frame did not restart timeout");
  a_err_alarm_limit: assert property (!errOff && !errClear && $stable(errLimit) && errCnt_q >= errLimit
    |=> errorAlarm)
    else $error("error alarm missing at limit");
  a_reply_zero_wait: assert property (rpState_q == RP_IDLE && requestDone && waitTenthMs == 14'h0000
    |-> ##3 replyStart)
    else $error("zero wait reply not three cycles");
  a_reply_exc_mode: assert property (replyStart |-> replyException == ($past(rpErr_q) && $past(errRespMode)))
    else $error("exception reply mode ignored");
  a_group_disabled: assert property (configCmd && groupIdCfg == rscc_pkg::GRP_OFF |=> !groupEnable)
    else $error("group left enabled");
  a_serial_random: assert property ($rose(powerUp_q) && !$past(serialEnable) |-> serialNumber <= rscc_pkg::SERIAL_MAX)
    else $error("random serial out of range");

  c_reply_exception: cover property (replyStart && replyException);
  c_timeout_alarm: cover property ($rose(timeoutAlarm));
  c_error_alarm: cover property ($rose(errorAlarm));
  c_fifo_full: cover property (!rxReady);
endmodule

/* sim/rscc_master_model.sv */
// Purpose: Bus master and frame engine stand-in that feeds the block
// Assumes: Every call drives just after a rising edge, pulses last one cycle
// Notes:   Idle address and data lines show the inverse of the last value
`timescale 1ns/1ps
// ==========================================
// Far side model
module rscc_master_model (
  input  wire logic       clock,
  input  wire logic       rxReady,
  input  wire logic       monValid,
  input  wire logic [7:0] monData,
  output logic            frameValid,
  output logic [3:0]      frameAddr,
  output logic            frameError,
  output logic            requestDone,
  output logic            slaveError,
  output logic            rxByteValid,
  output logic            rxByteOwn,
  output logic [7:0]      rxByte,
  output logic            monReady
);
  initial begin
    frameValid = 1'h0;
    frameAddr = 4'h0;
    frameError = 1'h0;
    requestDone = 1'h0;
    slaveError = 1'h0;
    rxByteValid = 1'h0;
    rxByteOwn = 1'h0;
    rxByte = 8'h00;
    monReady = 1'h0;
  end
  // Valid frame to one address; only own or group ones restart the timeout
  task automatic send_frame(input logic [3:0] addr);
    @(posedge clock);
    frameValid <= 1'h1;
    frameAddr <= addr;
    @(posedge clock);
    frameValid <= 1'h0;
    frameAddr <= ~addr;
  endtask
  task automatic send_error();
    @(posedge clock);
    frameError <= 1'h1;
    @(posedge clock);
    frameError <= 1'h0;
  endtask
  // Slave error level is only meaningful with the request pulse
  task automatic send_request(input logic err);
    @(posedge clock);
    requestDone <= 1'h1;
    slaveError <= err;
    @(posedge clock);
    requestDone <= 1'h0;
    slaveError <= ~err;
  endtask
  // Bytes are never retried, so a full buffer loses them
  task automatic offer_byte(input logic [7:0] b, input logic own);
    @(posedge clock);
    rxByteValid <= 1'h1;
    rxByte <= b;
    rxByteOwn <= own;
    @(posedge clock);
    rxByteValid <= 1'h0;
    rxByte <= ~b;
    rxByteOwn <= ~own;
  endtask
  // Ready is held until the edge where valid is seen; data is taken at that edge
  task automatic pop_byte(output logic [7:0] b, output logic ok);
    ok = 1'h0;
    b = 8'h00;
    @(posedge clock);
    monReady <= 1'h1;
    for (int n = 0; n < 40 && !ok; n++) begin
      @(posedge clock);
      if (monValid === 1'h1) begin
        ok = 1'h1;
        b = monData;
      end
    end
    monReady <= 1'h0;
  endtask
endmodule

/* sim/tb_rscc_comm_config.sv */
// Purpose: Self-checking bench for the serial port configuration block
// Assumes: Short tick of 10 cycles so waits and timeouts stay brief
// Notes:   Bit divisor may be truncated or rounded, both are accepted
`timescale 1ns/1ps
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin numErrors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_rscc_comm_config;
  localparam int TICK = 10;
  logic        clock, nrst, stopCode, errRespMode, monitorMode, serialEnable, configCmd, errClear;
  logic [2:0]  baudCode;
  logic [1:0]  parityCode, orderCode;
  logic [4:0]  slaveIdCfg, groupIdCfg, productCfg, productCode;
  logic [3:0]  addrSwitch, errLimit, ownAddr, groupAddr, frameAddr;
  logic [13:0] timeoutMs, waitTenthMs;
  logic [6:0]  silentTenthMs;
  logic [29:0] serialCfg, serialNumber;
  logic        frameValid, frameError, requestDone, slaveError, rxByteValid, rxByteOwn, rxReady;
  logic        monValid, monReady, parityEnable, parityOdd, stopTwo, groupEnable, wordLowFirst;
  logic        byteLittle, timeoutAlarm, errorAlarm, replyStart, replyException, ok;
  logic [7:0]  rxByte, monData, b;
  logic [15:0] bitDivisor;
  logic [23:0] silentCycles;
  int          numErrors, nCompared, n;
  int          rates[6] = '{9600, 19200, 38400, 57600, 115200, 230400};

  rscc_comm_config #(.TICK_CYCLES(TICK)) uut (.clock, .nrst, .baudCode, .parityCode, .stopCode,
    .slaveIdCfg, .addrSwitch, .orderCode, .timeoutMs, .errLimit, .waitTenthMs, .silentTenthMs,
    .errRespMode, .groupIdCfg, .monitorMode, .serialEnable, .serialCfg, .productCfg, .configCmd,
    .frameValid, .frameAddr, .frameError, .errClear, .requestDone, .slaveError, .rxByteValid,
    .rxByteOwn, .rxByte, .rxReady, .monValid, .monReady, .monData, .bitDivisor, .parityEnable,
    .parityOdd, .stopTwo, .ownAddr, .groupAddr, .groupEnable, .wordLowFirst, .byteLittle,
    .silentCycles, .timeoutAlarm, .errorAlarm, .replyStart, .replyException, .serialNumber,
    .productCode);
  rscc_master_model master (.clock, .rxReady, .monValid, .monData, .frameValid, .frameAddr,
    .frameError, .requestDone, .slaveError, .rxByteValid, .rxByteOwn, .rxByte, .monReady);

  // ==========================================
  // Shared helpers
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Bounded wait on one output: 0 timeout alarm, 1 reply pulse
  task automatic wait_out(input int sel, input int bound, output int cnt);
    cnt = 0;
    do begin
      @(posedge clock);
      #1;
      cnt++;
      if (cnt > bound) begin
        numErrors++;
        report_and_stop();
      end
    end while (((sel == 0) ? timeoutAlarm : replyStart) !== 1'h1);
  endtask
  task automatic pulse_cfg();
    @(posedge clock);
    configCmd <= 1'h1;
    @(posedge clock);
    configCmd <= 1'h0;
    @(posedge clock);
    #1;
  endtask
  task automatic chk_div(input int rate);
    int e;
    e = rscc_pkg::CLK_HZ / rate;
    `CHK((bitDivisor == 16'(e)) || (bitDivisor == 16'(e + 1)), 1'h1)
  endtask

  // ==========================================
  // Scenarios
  task automatic t_powerup();
    @(posedge clock);
    @(posedge clock);
    #1;
    chk_div(115200);
    `CHK(serialNumber, 30'h0ABCDEF1)
    `CHK(productCode, 5'h1F)
    `CHK({wordLowFirst, byteLittle}, 2'h1)
    `CHK(silentCycles, 24'(7 * TICK))
    `CHK(groupEnable, 1'h0)
    $display("powerup done");
  endtask
  task automatic t_config();
    for (int i = 0; i < 6; i++) begin
      baudCode <= 3'(i);
      parityCode <= 2'(i % 3);
      stopCode <= i[0];
      slaveIdCfg <= (i < 3) ? 5'h1F : 5'(i + 10);
      orderCode <= 2'h3;
      pulse_cfg();
      chk_div(rates[i]);
      `CHK(parityEnable, 1'((i % 3) != 0))
      `CHK(parityOdd, 1'((i % 3) == 2))
      `CHK(stopTwo, i[0])
      `CHK(ownAddr, (i < 3) ? 4'hC : 4'(i + 10))
    end
    // Rate and order must not move without the command or a power-up
    baudCode <= 3'h0;
    repeat (3) @(posedge clock);
    #1;
    chk_div(230400);
    `CHK({wordLowFirst, byteLittle}, 2'h1)
    $display("config done");
  endtask
  task automatic t_timeout();
    timeoutMs <= 14'h0001;
    master.send_frame(4'hF);
    wait_out(0, 200, n);
    `CHK((n >= 98) && (n <= 113), 1'h1)
    master.send_frame(4'h3);
    @(posedge clock);
    #1;
    `CHK(timeoutAlarm, 1'h1)
    master.send_frame(4'hF);
    @(posedge clock);
    #1;
    `CHK(timeoutAlarm, 1'h0)
    groupIdCfg <= 5'h07;
    pulse_cfg();
    `CHK({groupEnable, groupAddr}, 5'h17)
    wait_out(0, 200, n);
    master.send_frame(4'h7);
    @(posedge clock);
    #1;
    `CHK(timeoutAlarm, 1'h0)
    wait_out(0, 200, n);
    timeoutMs <= 14'h0000;
    repeat (2) @(posedge clock);
    #1;
    `CHK(timeoutAlarm, 1'h0)
    $display("timeout done");
  endtask
  task automatic t_errors();
    errLimit <= 4'h3;
    master.send_error();
    master.send_error();
    repeat (2) @(posedge clock);
    #1;
    `CHK(errorAlarm, 1'h0)
    master.send_error();
    @(posedge clock);
    #1;
    `CHK(errorAlarm, 1'h1)
    @(posedge clock);
    errClear <= 1'h1;
    @(posedge clock);
    errClear <= 1'h0;
    @(posedge clock);
    #1;
    `CHK(errorAlarm, 1'h0)
    errLimit <= 4'h1;
    master.send_error();
    @(posedge clock);
    #1;
    `CHK(errorAlarm, 1'h1)
    errLimit <= 4'h0;
    repeat (2) @(posedge clock);
    #1;
    `CHK(errorAlarm, 1'h0)
    $display("errors done");
  endtask
  task automatic t_reply(input logic [13:0] w, input logic mode);
    waitTenthMs <= w;
    errRespMode <= mode;
    master.send_request(1'h1);
    wait_out(1, 400, n);
    `CHK(n, int'(w) * TICK + 2)
    `CHK(replyException, mode)
    @(posedge clock);
    #1;
    `CHK(replyStart, 1'h0)
    $display("reply done");
  endtask
  task automatic t_monitor();
    monitorMode <= 1'h1;
    master.offer_byte(8'h55, 1'h0);
    for (int i = 0; i < 16; i++) master.offer_byte(8'hA0 + 8'(i), 1'h1);
    @(posedge clock);
    #1;
    `CHK(rxReady, 1'h0)
    master.offer_byte(8'hEE, 1'h1);
    monitorMode <= 1'h0;
    for (int i = 0; i < 16; i++) begin
      master.pop_byte(b, ok);
      `CHK({ok, b}, {1'h1, 8'hA0 + 8'(i)})
    end
    master.offer_byte(8'h77, 1'h0);
    master.pop_byte(b, ok);
    `CHK({ok, b}, 9'h177)
    $display("monitor done");
  endtask
  task automatic t_reset2();
    @(posedge clock);
    nrst <= 1'h0;
    serialEnable <= 1'h0;
    serialCfg <= 30'h3B9AC9FF;
    orderCode <= 2'h1;
    silentTenthMs <= 7'h00;
    repeat (3) @(posedge clock);
    nrst <= 1'h1;
    repeat (2) @(posedge clock);
    #1;
    `CHK((serialNumber <= 30'h1FFFFFFF) && (serialNumber != serialCfg), 1'h1)
    `CHK({wordLowFirst, byteLittle}, 2'h2)
    `CHK(silentCycles, 24'((rscc_pkg::CLK_HZ / 9600) * rscc_pkg::GAP_HALF_BITS / 2))
    $display("reset2 done");
  endtask

  // ==========================================
  // Main sequence
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  initial begin
    numErrors = 0;
    nCompared = 0;
    nrst = 1'h0;
    {baudCode, parityCode, stopCode, orderCode} = {3'h4, 2'h0, 1'h0, 2'h2};
    {slaveIdCfg, addrSwitch, groupIdCfg, configCmd, errClear} = {5'h1F, 4'hC, 5'h1F, 2'h0};
    {timeoutMs, errLimit, waitTenthMs, silentTenthMs} = {14'h0, 4'h0, 14'h1E, 7'h07};
    {errRespMode, monitorMode, serialEnable} = 3'h5;
    serialCfg = 30'h0ABCDEF1;
    productCfg = 5'h1F;
    repeat (3) @(posedge clock);
    nrst <= 1'h1;
    t_powerup();
    t_config();
    t_timeout();
    t_errors();
    t_reply(14'h0002, 1'h1);
    t_reply(14'h0000, 1'h0);
    t_monitor();
    t_reset2();
    report_and_stop();
  end
endmodule
